/* File: pkg/fbx_pkg.sv */
// shared constants and types of the fieldbus telegram engine
`default_nettype none
package fbx_pkg;
	// frame types
	localparam logic [15:0] FBX_ETYPE_FB    = 16'h88a4;
	localparam logic [15:0] FBX_ETYPE_IP    = 16'h0800;
	localparam logic [3:0]  FBX_FB_TYPE     = 4'h1;
	// arbitrary source address of the master end
	localparam logic [47:0] FBX_SRC_MAC     = 48'h020000000001;
	// section lengths in bytes
	localparam logic [10:0] FBX_ETH_HDR_LEN = 11'h00e;
	localparam logic [10:0] FBX_IPUDP_LEN   = 11'h01c;
	localparam logic [10:0] FBX_FB_HDR_LEN  = 11'h002;
	localparam logic [10:0] FBX_TG_HDR_LEN  = 11'h00a;
	localparam logic [10:0] FBX_WKC_LEN     = 11'h002;
	localparam logic [10:0] FBX_M_HDR_LEN   = FBX_ETH_HDR_LEN + FBX_FB_HDR_LEN + FBX_TG_HDR_LEN;
	// byte positions
	localparam logic [10:0] FBX_ETH_TYPE_HI = 11'h00c;
	localparam logic [10:0] FBX_TH_CMD      = 11'h000;
	localparam logic [10:0] FBX_TH_ADP_LO   = 11'h002;
	localparam logic [10:0] FBX_TH_ADP_HI   = 11'h003;
	localparam logic [10:0] FBX_TH_ADO_LO   = 11'h004;
	localparam logic [10:0] FBX_TH_ADO_HI   = 11'h005;
	localparam logic [10:0] FBX_TH_LEN_LO   = 11'h006;
	localparam logic [10:0] FBX_TH_LEN_HI   = 11'h007;
	localparam int          FBX_MORE_BIT    = 7;
	// service codes
	localparam logic [7:0]  FBX_CMD_APRD    = 8'h01;
	localparam logic [7:0]  FBX_CMD_APWR    = 8'h02;
	localparam logic [7:0]  FBX_CMD_APRW    = 8'h03;
	localparam logic [7:0]  FBX_CMD_FPRD    = 8'h04;
	localparam logic [7:0]  FBX_CMD_FPWR    = 8'h05;
	localparam logic [7:0]  FBX_CMD_FPRW    = 8'h06;
	localparam logic [7:0]  FBX_CMD_BRD     = 8'h07;
	localparam logic [7:0]  FBX_CMD_BWR     = 8'h08;
	localparam logic [7:0]  FBX_CMD_LRD     = 8'h0a;
	localparam logic [7:0]  FBX_CMD_LWR     = 8'h0b;
	localparam logic [7:0]  FBX_CMD_LRW     = 8'h0c;
	localparam logic [7:0]  FBX_CMD_ARMW    = 8'h0d;
	localparam logic [7:0]  FBX_CMD_FRMW    = 8'h0e;
	// structure sizes
	localparam int          FBX_MEM_AW      = 8;
	localparam int          FBX_FIFO_W      = 9;
	localparam int          FBX_FIFO_DEPTH  = 8;
	// parser phases of the slave end
	typedef enum logic [6:0] {
		FBX_SP_ETH  = 7'h01,
		FBX_SP_UDP  = 7'h02,
		FBX_SP_FBH  = 7'h04,
		FBX_SP_THD  = 7'h08,
		FBX_SP_DATA = 7'h10,
		FBX_SP_WKC  = 7'h20,
		FBX_SP_PASS = 7'h40
	} fbx_sph_t;
	// builder phases of the master end
	typedef enum logic [3:0] {
		FBX_MP_IDLE = 4'h1,
		FBX_MP_HDR  = 4'h2,
		FBX_MP_DATA = 4'h4,
		FBX_MP_WKC  = 4'h8
	} fbx_mph_t;
endpackage
`default_nettype wire

/* File: pkg/fbx_link_if.sv */
// byte link between the master end and the slave end
`default_nettype none
interface fbx_link_if;
	logic       fwd_valid;
	logic [7:0] fwd_data;
	logic       fwd_last;
	logic       fwd_ready;
	logic       ret_valid;
	logic [7:0] ret_data;
	logic       ret_last;
	modport master (output fwd_valid, fwd_data, fwd_last, input fwd_ready,
		input ret_valid, ret_data, ret_last);
	modport slave (input fwd_valid, fwd_data, fwd_last, output fwd_ready,
		output ret_valid, ret_data, ret_last);
endinterface
`default_nettype wire

/* File: rtl/fbx_slave_end.sv */
// slave end: input fifo and on-the-fly telegram processing engine
`default_nettype none
module fbx_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             arst_n,
	// fill side
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	// drain side
	output logic                  out_valid,
	output logic [WIDTH-1:0]      out_data,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW:0] wp;
		logic [AW:0] rp;
	} fbx_fifo_st_t;
	fbx_fifo_st_t q, n;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push, pop, full, empty;

	// extra pointer bit tells full from empty; depth must be a power of two
	assign full      = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);
	assign empty     = (q.wp == q.rp);
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem[q.rp[AW-1:0]];
	assign push      = in_valid && !full;
	assign pop       = !empty && out_ready;

	// pointer update
	always_comb begin
		n = q;
		if (push) begin
			n.wp = q.wp + 1'b1;
		end
		if (pop) begin
			n.rp = q.rp + 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	// storage needs no reset, only the pointers do
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[q.wp[AW-1:0]] <= in_data;
		end
	end
endmodule

// Overview of operation
// - only the fieldbus and IP frame types are processed
// - every telegram of a frame handled in turn
// - accept direct and UDP-carried telegrams
// - telegram is header, data, work counter
// - exchanging slave adds one to work counter
// - process bytes in flight, then forward downstream
// - last slave returns frame toward master
// - master addresses up to 65535 positions
// - services access the local physical memory
// - position read, write, read-write by chain position
// - configured-address read, write, read-write
// - broadcast read and write hit every slave
// - logical services via mapped logical window
// - selected slave reads, all other slaves write
// - mapping gives physical, logical start, length, direction
// - node addressing matches assigned station address
module fbx_slave_end
	import fbx_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	// link toward the master
	fbx_link_if.slave        up,
	// commissioning settings
	input  wire logic [15:0] station_addr,
	input  wire logic        last_in_segment,
	input  wire logic        fmmu_enable,
	input  wire logic [31:0] fmmu_log_start,
	input  wire logic [15:0] fmmu_len,
	input  wire logic [7:0]  fmmu_phys_start,
	input  wire logic        fmmu_dir_out,
	// stream toward the next slave
	output logic             dn_valid,
	output logic [7:0]       dn_data,
	output logic             dn_last,
	input  wire logic        dn_ready,
	// stream returned by the next slave
	input  wire logic        nx_ret_valid,
	input  wire logic [7:0]  nx_ret_data,
	input  wire logic        nx_ret_last
);
	typedef struct packed {
		fbx_sph_t    ph;
		logic [10:0] cnt;
		logic [7:0]  tbyte;
		logic [7:0]  cmd;
		logic [15:0] adp;
		logic [15:0] ado;
		logic [10:0] len;
		logic        more;
		logic        sel;
		logic        inc;
		logic        carry;
		logic        dn_valid;
		logic [7:0]  dn_data;
		logic        dn_last;
		logic        ret_valid;
		logic [7:0]  ret_data;
		logic        ret_last;
	} fbx_slave_st_t;
	fbx_slave_st_t q, n;

	logic [7:0] mem [2**FBX_MEM_AW];
	logic       f_valid, f_last, take, wr_en;
	logic [7:0] f_byte, mem_q, pa;
	logic       is_pos, is_fix, is_brd, is_log, is_rmw, can_rd, can_wr;
	logic       sel_now, hit, do_rd, do_wr, adp_inc;
	logic [31:0] la, loff;

	// input buffer; a full buffer holds the master off through fwd_ready
	fbx_fifo #(.WIDTH(FBX_FIFO_W), .DEPTH(FBX_FIFO_DEPTH)) fbx_fifo_inst (
		.ref_clk   (ref_clk),
		.arst_n    (arst_n),
		.in_valid  (up.fwd_valid),
		.in_data   ({up.fwd_last, up.fwd_data}),
		.in_ready  (up.fwd_ready),
		.out_valid (f_valid),
		.out_data  ({f_last, f_byte}),
		.out_ready (take)
	);

	// a byte moves when the chosen output register is free
	assign take = f_valid && (last_in_segment || !q.dn_valid || dn_ready);

	// service decode
	assign is_pos = (q.cmd == FBX_CMD_APRD) || (q.cmd == FBX_CMD_APWR) ||
		(q.cmd == FBX_CMD_APRW) || (q.cmd == FBX_CMD_ARMW);
	assign is_fix = (q.cmd == FBX_CMD_FPRD) || (q.cmd == FBX_CMD_FPWR) ||
		(q.cmd == FBX_CMD_FPRW) || (q.cmd == FBX_CMD_FRMW);
	assign is_brd = (q.cmd == FBX_CMD_BRD) || (q.cmd == FBX_CMD_BWR);
	assign is_log = (q.cmd == FBX_CMD_LRD) || (q.cmd == FBX_CMD_LWR) ||
		(q.cmd == FBX_CMD_LRW);
	assign is_rmw = (q.cmd == FBX_CMD_ARMW) || (q.cmd == FBX_CMD_FRMW);
	assign can_rd = (q.cmd == FBX_CMD_APRD) || (q.cmd == FBX_CMD_APRW) ||
		(q.cmd == FBX_CMD_FPRD) || (q.cmd == FBX_CMD_FPRW) || (q.cmd == FBX_CMD_BRD) ||
		(q.cmd == FBX_CMD_LRD) || (q.cmd == FBX_CMD_LRW);
	assign can_wr = (q.cmd == FBX_CMD_APWR) || (q.cmd == FBX_CMD_APRW) ||
		(q.cmd == FBX_CMD_FPWR) || (q.cmd == FBX_CMD_FPRW) || (q.cmd == FBX_CMD_BWR) ||
		(q.cmd == FBX_CMD_LWR) || (q.cmd == FBX_CMD_LRW);
	assign adp_inc = is_pos || is_brd;

	// selection at the end of the header, from the address as received
	assign sel_now = (is_pos && (q.adp == 16'h0000)) ||
		(is_fix && (q.adp == station_addr)) ||
		is_brd || is_log;

	// logical window translated through the single mapping unit
	assign la    = {q.adp, q.ado} + {21'h000000, q.cnt};
	assign loff  = la - fmmu_log_start;
	assign hit   = fmmu_enable && (la >= fmmu_log_start) &&
		(loff < {16'h0000, fmmu_len});
	assign pa    = is_log ? (fmmu_phys_start + loff[7:0]) : (q.ado[7:0] + q.cnt[7:0]);
	assign mem_q = mem[pa];

	// who reads and who writes this data byte
	always_comb begin
		do_rd = 1'b0;
		do_wr = 1'b0;
		if (is_rmw) begin
			do_rd = q.sel;
			do_wr = !q.sel;
		end else if (is_log) begin
			do_rd = hit && can_rd && !fmmu_dir_out;
			do_wr = hit && can_wr && fmmu_dir_out;
		end else begin
			do_rd = q.sel && can_rd;
			do_wr = q.sel && can_wr;
		end
	end
	assign wr_en = take && (q.ph == FBX_SP_DATA) && do_wr;

	// parser and byte rewriting
	always_comb begin
		logic [7:0] obyte;
		obyte = f_byte;
		n = q;
		if (q.dn_valid && dn_ready) begin
			n.dn_valid = 1'b0;
		end
		// returns from further down only pass through when not last
		n.ret_valid = !last_in_segment && nx_ret_valid;
		n.ret_data  = nx_ret_data;
		n.ret_last  = nx_ret_last;
		if (take) begin
			n.cnt = q.cnt + 11'h001;
			unique case (q.ph)
				FBX_SP_ETH: begin
					if (q.cnt == FBX_ETH_TYPE_HI) begin
						n.tbyte = f_byte;
					end
					if (q.cnt == FBX_ETH_HDR_LEN - 11'h001) begin
						n.cnt = '0;
						if ({q.tbyte, f_byte} == FBX_ETYPE_FB) begin
							n.ph = FBX_SP_FBH;
						end else if ({q.tbyte, f_byte} == FBX_ETYPE_IP) begin
							n.ph = FBX_SP_UDP;
						end else begin
							n.ph = FBX_SP_PASS;
						end
					end
				end
				FBX_SP_UDP: begin
					if (q.cnt == FBX_IPUDP_LEN - 11'h001) begin
						n.cnt = '0;
						n.ph  = FBX_SP_FBH;
					end
				end
				FBX_SP_FBH: begin
					if (q.cnt == FBX_FB_HDR_LEN - 11'h001) begin
						n.cnt = '0;
						n.ph  = FBX_SP_THD;
					end
				end
				FBX_SP_THD: begin
					if (q.cnt == FBX_TH_CMD) begin
						n.cmd = f_byte;
					end
					if (q.cnt == FBX_TH_ADP_LO) begin
						n.adp[7:0] = f_byte;
						n.carry    = (f_byte == 8'hff);
						if (adp_inc) begin
							obyte = f_byte + 8'h01;
						end
					end
					if (q.cnt == FBX_TH_ADP_HI) begin
						n.adp[15:8] = f_byte;
						if (adp_inc) begin
							obyte = f_byte + {7'h00, q.carry};
						end
					end
					if (q.cnt == FBX_TH_ADO_LO) begin
						n.ado[7:0] = f_byte;
					end
					if (q.cnt == FBX_TH_ADO_HI) begin
						n.ado[15:8] = f_byte;
					end
					if (q.cnt == FBX_TH_LEN_LO) begin
						n.len[7:0] = f_byte;
					end
					if (q.cnt == FBX_TH_LEN_HI) begin
						n.len[10:8] = f_byte[2:0];
						n.more      = f_byte[FBX_MORE_BIT];
					end
					if (q.cnt == FBX_TG_HDR_LEN - 11'h001) begin
						n.cnt = '0;
						n.sel = sel_now;
						n.inc = 1'b0;
						n.ph  = (q.len == 11'h000) ? FBX_SP_WKC : FBX_SP_DATA;
					end
				end
				FBX_SP_DATA: begin
					if (do_rd) begin
						obyte = is_brd ? (f_byte | mem_q) : mem_q;
					end
					if (do_rd || do_wr) begin
						n.inc = 1'b1;
					end
					if (q.cnt == q.len - 11'h001) begin
						n.cnt = '0;
						n.ph  = FBX_SP_WKC;
					end
				end
				FBX_SP_WKC: begin
					if (q.cnt == 11'h000) begin
						obyte   = f_byte + {7'h00, q.inc};
						n.carry = q.inc && (f_byte == 8'hff);
					end else begin
						obyte = f_byte + {7'h00, q.carry};
						n.cnt = '0;
						n.ph  = q.more ? FBX_SP_THD : FBX_SP_PASS;
					end
				end
				FBX_SP_PASS: begin
					n.cnt = q.cnt;
				end
			endcase
			if (f_last) begin
				n.ph  = FBX_SP_ETH;
				n.cnt = '0;
			end
			if (last_in_segment) begin
				n.ret_valid = 1'b1;
				n.ret_data  = obyte;
				n.ret_last  = f_last;
			end else begin
				n.dn_valid = 1'b1;
				n.dn_data  = obyte;
				n.dn_last  = f_last;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			q    <= '0;
			q.ph <= FBX_SP_ETH;
		end else begin
			q <= n;
		end
	end

	// physical memory written by write services
	always_ff @(posedge ref_clk) begin
		if (wr_en) begin
			mem[pa] <= f_byte;
		end
	end

	// outputs come straight from the state register
	assign dn_valid     = q.dn_valid;
	assign dn_data      = q.dn_data;
	assign dn_last      = q.dn_last;
	assign up.ret_valid = q.ret_valid;
	assign up.ret_data  = q.ret_data;
	assign up.ret_last  = q.ret_last;
endmodule
`default_nettype wire

/* File: rtl/fbx_master_end.sv */
// master end: builds one-telegram frames and collects the returned frame
`default_nettype none
module fbx_master_end
	import fbx_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	// link toward the first slave
	fbx_link_if.master       dn,
	// telegram request
	input  wire logic        req_valid,
	input  wire logic [7:0]  req_cmd,
	input  wire logic [15:0] req_adp,
	input  wire logic [15:0] req_ado,
	input  wire logic [10:0] req_len,
	output logic             req_ready,
	// telegram data bytes
	input  wire logic        wdat_valid,
	input  wire logic [7:0]  wdat_data,
	output logic             wdat_ready,
	// returned frame
	output logic             rx_valid,
	output logic [7:0]       rx_data,
	output logic             rx_last,
	output logic [15:0]      rx_wkc,
	output logic             rx_done
);
	typedef struct packed {
		fbx_mph_t    ph;
		logic [10:0] cnt;
		logic [7:0]  cmd;
		logic [15:0] adp;
		logic [15:0] ado;
		logic [10:0] len;
		logic        fwd_valid;
		logic [7:0]  fwd_data;
		logic        fwd_last;
		logic        req_ready;
		logic        wdat_ready;
		logic        rx_valid;
		logic [7:0]  rx_data;
		logic        rx_last;
		logic [11:0] rcnt;
		logic [7:0]  wkc_lo;
		logic [15:0] rx_wkc;
		logic        rx_done;
	} fbx_master_st_t;
	fbx_master_st_t q, n;
	logic        adv, pos_cmd;
	logic [11:0] wkc_pos;

	// header byte i of an outgoing frame
	function automatic logic [7:0] hdr_byte(input logic [10:0] i, input logic [7:0] c,
		input logic [15:0] a, input logic [15:0] o, input logic [10:0] l);
		logic [10:0] fl;
		logic [7:0]  b;
		fl = FBX_TG_HDR_LEN + l + FBX_WKC_LEN;
		b  = 8'h00;
		if (i < 11'h006) begin
			b = 8'hff;
		end else if (i < FBX_ETH_TYPE_HI) begin
			b = FBX_SRC_MAC[8*(11-i[3:0]) +: 8];
		end else begin
			unique case (i)
				11'h00c: b = FBX_ETYPE_FB[15:8];
				11'h00d: b = FBX_ETYPE_FB[7:0];
				11'h00e: b = fl[7:0];
				11'h00f: b = {FBX_FB_TYPE, 1'b0, fl[10:8]};
				11'h010: b = c;
				11'h012: b = a[7:0];
				11'h013: b = a[15:8];
				11'h014: b = o[7:0];
				11'h015: b = o[15:8];
				11'h016: b = l[7:0];
				11'h017: b = {5'h00, l[10:8]};
				default: b = 8'h00;
			endcase
		end
		return b;
	endfunction

	assign adv     = !q.fwd_valid || dn.fwd_ready;
	assign pos_cmd = (req_cmd == FBX_CMD_APRD) || (req_cmd == FBX_CMD_APWR) ||
		(req_cmd == FBX_CMD_APRW) || (req_cmd == FBX_CMD_ARMW);
	assign wkc_pos = {1'b0, FBX_M_HDR_LEN + q.len};

	// frame builder and return collector
	always_comb begin
		n = q;
		n.rx_done = 1'b0;
		if (q.fwd_valid && dn.fwd_ready) begin
			n.fwd_valid = 1'b0;
		end
		unique case (q.ph)
			FBX_MP_IDLE: begin
				if (req_valid && q.req_ready) begin
					n.cmd       = req_cmd;
					// position k is sent as minus k; the slave at k counts it to zero
					n.adp       = pos_cmd ? (16'h0000 - req_adp) : req_adp;
					n.ado       = req_ado;
					n.len       = req_len;
					n.req_ready = 1'b0;
					n.cnt       = '0;
					n.ph        = FBX_MP_HDR;
				end
			end
			FBX_MP_HDR: begin
				if (adv) begin
					n.fwd_valid = 1'b1;
					n.fwd_data  = hdr_byte(q.cnt, q.cmd, q.adp, q.ado, q.len);
					n.fwd_last  = 1'b0;
					n.cnt       = q.cnt + 11'h001;
					if (q.cnt == FBX_M_HDR_LEN - 11'h001) begin
						n.cnt = '0;
						n.ph  = (q.len == 11'h000) ? FBX_MP_WKC : FBX_MP_DATA;
					end
				end
			end
			FBX_MP_DATA: begin
				if (wdat_valid && q.wdat_ready) begin
					n.fwd_valid = 1'b1;
					n.fwd_data  = wdat_data;
					n.fwd_last  = 1'b0;
					n.cnt       = q.cnt + 11'h001;
					if (q.cnt == q.len - 11'h001) begin
						n.cnt = '0;
						n.ph  = FBX_MP_WKC;
					end
				end
			end
			FBX_MP_WKC: begin
				if (adv) begin
					n.fwd_valid = 1'b1;
					n.fwd_data  = 8'h00;
					n.fwd_last  = (q.cnt == 11'h001);
					n.cnt       = q.cnt + 11'h001;
					if (q.cnt == 11'h001) begin
						n.cnt = '0;
						n.ph  = FBX_MP_IDLE;
					end
				end
			end
		endcase
		// one byte in flight at a time keeps wdat_ready a plain register
		n.wdat_ready = (n.ph == FBX_MP_DATA) && !n.fwd_valid;
		n.rx_valid   = dn.ret_valid;
		n.rx_data    = dn.ret_data;
		n.rx_last    = dn.ret_last;
		if (dn.ret_valid) begin
			n.rcnt = q.rcnt + 12'h001;
			if (q.rcnt == wkc_pos) begin
				n.wkc_lo = dn.ret_data;
			end
			if (q.rcnt == wkc_pos + 12'h001) begin
				n.rx_wkc  = {dn.ret_data, q.wkc_lo};
				n.rx_done = 1'b1;
			end
			if (dn.ret_last) begin
				n.rcnt = '0;
				// next request only once the previous frame is home
				if (q.ph == FBX_MP_IDLE) begin
					n.req_ready = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			q           <= '0;
			q.ph        <= FBX_MP_IDLE;
			q.req_ready <= 1'b1;
		end else begin
			q <= n;
		end
	end

	assign dn.fwd_valid = q.fwd_valid;
	assign dn.fwd_data  = q.fwd_data;
	assign dn.fwd_last  = q.fwd_last;
	assign req_ready    = q.req_ready;
	assign wdat_ready   = q.wdat_ready;
	assign rx_valid     = q.rx_valid;
	assign rx_data      = q.rx_data;
	assign rx_last      = q.rx_last;
	assign rx_wkc       = q.rx_wkc;
	assign rx_done      = q.rx_done;
endmodule
`default_nettype wire

/* File: test/fbx_props.sv */
// link checker: watches the byte link between the two ends
`default_nettype none
module fbx_props (
	// clock and reset
	input wire logic       ref_clk,
	input wire logic       arst_n,
	// forward stream
	input wire logic       fwd_valid,
	input wire logic [7:0] fwd_data,
	input wire logic       fwd_last,
	input wire logic       fwd_ready,
	// returned stream
	input wire logic       ret_valid,
	input wire logic [7:0] ret_data,
	input wire logic       ret_last
);
	logic [10:0] fcnt;
	logic [10:0] rcnt;
	logic [10:0] flen;
	logic [10:0] ftot;
	logic [7:0]  fcmd;
	logic        tk;
	assign tk = fwd_valid && fwd_ready;
	// byte positions; only one frame is in flight since the master waits for its return
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			fcnt <= 11'h000;
			rcnt <= 11'h000;
			flen <= 11'h000;
			ftot <= 11'h000;
			fcmd <= 8'h00;
		end else begin
			if (tk)
				fcnt <= fwd_last ? 11'h000 : fcnt + 11'h001;
			if (tk && fwd_last)
				ftot <= fcnt + 11'h001;
			if (tk && fcnt == 11'h010)
				fcmd <= fwd_data;
			if (tk && fcnt == 11'h016)
				flen[7:0] <= fwd_data;
			if (tk && fcnt == 11'h017)
				flen[10:8] <= fwd_data[2:0];
			if (ret_valid)
				rcnt <= ret_last ? 11'h000 : rcnt + 11'h001;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	sequence s_fwd_end;
		fwd_valid && fwd_ready && fwd_last;
	endsequence
	sequence s_ret_end;
		ret_valid && ret_last;
	endsequence
	property p_fwd_hold;
		fwd_valid && !fwd_ready |=> fwd_valid && $stable(fwd_data) && $stable(fwd_last);
	endproperty
	a_fwd_hold: assert property (p_fwd_hold) else $error("forward byte changed while refused");
	property p_ethtype;
		tk && (fcnt == 11'h00c || fcnt == 11'h00d) |-> fwd_data == (fcnt[0] ? 8'ha4 : 8'h88);
	endproperty
	a_ethtype: assert property (p_ethtype) else $error("frame type bytes wrong");
	property p_fwd_last;
		tk |-> fwd_last == (fcnt == 11'h01b + flen);
	endproperty
	a_fwd_last: assert property (p_fwd_last) else $error("frame end not after counter");
	property p_ret_done;
		s_fwd_end |-> ##[2:120] s_ret_end;
	endproperty
	a_ret_done: assert property (p_ret_done) else $error("frame not returned in time");
	property p_ret_len;
		s_ret_end |-> rcnt + 11'h001 == ftot;
	endproperty
	a_ret_len: assert property (p_ret_len) else $error("returned frame length differs");
	property p_ret_cmd;
		ret_valid && rcnt == 11'h010 |-> ret_data == fcmd;
	endproperty
	a_ret_cmd: assert property (p_ret_cmd) else $error("service code altered");
	property p_ret_type;
		ret_valid && rcnt == 11'h00d |-> ret_data == 8'ha4;
	endproperty
	a_ret_type: assert property (p_ret_type) else $error("returned frame type altered");
	property p_wkc_lo;
		ret_valid && rcnt == 11'h01a + flen |-> ret_data <= 8'h01;
	endproperty
	a_wkc_lo: assert property (p_wkc_lo) else $error("counter raised by more than one");
	property p_wkc_hi;
		ret_valid && rcnt == 11'h01b + flen |-> ret_data == 8'h00 && ret_last;
	endproperty
	a_wkc_hi: assert property (p_wkc_hi) else $error("counter high byte or end wrong");
endmodule
`default_nettype wire

/* File: test/fbx_tb.sv */
// bench: master end and slave end back to back, downstream looped back
`default_nettype none
module fbx_tb import fbx_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic        ref_clk, arst_n, last_in_segment, dn_ready, dn_valid, dn_last;
	logic        fmmu_enable, fmmu_dir_out, req_valid, req_ready, wdat_valid, wdat_ready;
	logic        rx_valid, rx_last, rx_done, saw_full;
	logic [15:0] station_addr, fmmu_len, req_adp, req_ado, rx_wkc;
	logic [31:0] fmmu_log_start;
	logic [10:0] req_len;
	logic [7:0]  fmmu_phys_start, dn_data, req_cmd, wdat_data, rx_data;
	int          failures, cmp_count;
	fbx_link_if link ();
	// downstream loopback stands in for a further slave that returns the frame
	fbx_slave_end fbx_slave_end_inst (.ref_clk(ref_clk), .arst_n(arst_n), .up(link),
		.station_addr(station_addr), .last_in_segment(last_in_segment),
		.fmmu_enable(fmmu_enable), .fmmu_log_start(fmmu_log_start), .fmmu_len(fmmu_len),
		.fmmu_phys_start(fmmu_phys_start), .fmmu_dir_out(fmmu_dir_out),
		.dn_valid(dn_valid), .dn_data(dn_data), .dn_last(dn_last), .dn_ready(dn_ready),
		.nx_ret_valid(dn_valid && dn_ready), .nx_ret_data(dn_data), .nx_ret_last(dn_last));
	fbx_master_end fbx_master_end_inst (.ref_clk(ref_clk), .arst_n(arst_n), .dn(link),
		.req_valid(req_valid), .req_cmd(req_cmd), .req_adp(req_adp), .req_ado(req_ado),
		.req_len(req_len), .req_ready(req_ready), .wdat_valid(wdat_valid),
		.wdat_data(wdat_data), .wdat_ready(wdat_ready), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_last(rx_last), .rx_wkc(rx_wkc), .rx_done(rx_done));
	fbx_props fbx_props_inst (.ref_clk(ref_clk), .arst_n(arst_n),
		.fwd_valid(link.fwd_valid), .fwd_data(link.fwd_data), .fwd_last(link.fwd_last),
		.fwd_ready(link.fwd_ready), .ret_valid(link.ret_valid), .ret_data(link.ret_data),
		.ret_last(link.ret_last));
	// clock at 40 MHz
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	// note when the slave fifo refuses a byte
	always @(negedge ref_clk) begin
		if (link.fwd_valid && !link.fwd_ready)
			saw_full = 1'b1;
	end
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, seen, exp);
		end
	endtask
	// data byte i of a pattern; base zero means all zero bytes
	function automatic logic [7:0] bv(input logic [7:0] b, input int i);
		return (b == 8'h00) ? 8'h00 : b + 8'(i);
	endfunction
	// one telegram: request, data bytes, then collect the returned frame
	task automatic tel(input logic [7:0] cmd, input logic [15:0] adp, input logic [15:0] ado,
		input logic [10:0] len, input logic [7:0] wb, input logic [7:0] eb,
		input logic [15:0] wkc);
		int  i;
		int  k;
		int  m;
		int  n;
		logic done;
		done = 1'b0;
		n = 0;
		fork
			begin
				@(negedge ref_clk);
				for (k = 0; k < 200 && !req_ready; k++)
					@(negedge ref_clk);
				check(16'(req_ready), 16'h0001, "request never ready");
				{req_valid, req_cmd, req_adp, req_ado, req_len} = {1'b1, cmd, adp, ado, len};
				@(negedge ref_clk);
				req_valid = 1'b0;
				i = 0;
				for (k = 0; k < 600 && i < len; k++) begin
					@(negedge ref_clk);
					if (wdat_valid) begin
						wdat_valid = 1'b0;
						i++;
					end else if (wdat_ready) begin
						wdat_valid = 1'b1;
						wdat_data = bv(wb, i);
					end
				end
				check(16'(i), 16'(len), "data bytes sent");
			end
			// own loop counter: the sending branch runs its own count in parallel
			for (m = 0; m < 900 && !done; m++) begin
				@(negedge ref_clk);
				if (rx_valid) begin
					if (n >= 26 && n < 26 + len)
						check(16'(rx_data), 16'(bv(eb, n - 26)), "data byte");
					if (rx_last)
						check(16'(n + 1), 16'(len) + 16'h001c, "frame length");
					n++;
				end
				if (rx_done) begin
					check(rx_wkc, wkc, "work counter");
					done = 1'b1;
				end
			end
		join
		if (!done) begin
			failures++;
			$display("MISMATCH at %0t: no returned frame", $time);
			wrap_up();
		end
		$display("test done: service %h address %h", cmd, adp);
	endtask
	// main sequence
	initial begin
		{arst_n, req_valid, wdat_valid, fmmu_enable, fmmu_dir_out, saw_full} = 6'h00;
		{last_in_segment, dn_ready, station_addr} = {2'h3, 16'h1234};
		{req_cmd, req_adp, req_ado, req_len, wdat_data} = '0;
		{fmmu_log_start, fmmu_len, fmmu_phys_start} = '0;
		{failures, cmp_count} = '0;
		repeat (20) @(negedge ref_clk);
		arst_n = 1'b1;
		tel(FBX_CMD_FPWR, 16'h1234, 16'h0010, 11'h004, 8'ha0, 8'ha0, 16'h0001);
		tel(FBX_CMD_FPRD, 16'h1234, 16'h0010, 11'h004, 8'h00, 8'ha0, 16'h0001);
		tel(FBX_CMD_FPRD, 16'h5555, 16'h0010, 11'h004, 8'h00, 8'h00, 16'h0000);
		tel(FBX_CMD_APWR, 16'h0000, 16'h0020, 11'h003, 8'hc0, 8'hc0, 16'h0001);
		tel(FBX_CMD_APRD, 16'h0001, 16'h0020, 11'h003, 8'h00, 8'h00, 16'h0000);
		tel(FBX_CMD_APRW, 16'h0000, 16'h0020, 11'h003, 8'hd0, 8'hc0, 16'h0001);
		tel(FBX_CMD_FPRW, 16'h1234, 16'h0020, 11'h003, 8'h00, 8'hd0, 16'h0001);
		tel(FBX_CMD_BWR, 16'h0000, 16'h0030, 11'h002, 8'h50, 8'h50, 16'h0001);
		tel(FBX_CMD_BRD, 16'h0000, 16'h0030, 11'h002, 8'h00, 8'h50, 16'h0001);
		{fmmu_enable, fmmu_log_start, fmmu_len, fmmu_phys_start} = {1'b1, 32'h00010000,
			16'h0004, 8'h40};
		fmmu_dir_out = 1'b1;
		tel(FBX_CMD_LWR, 16'h0001, 16'h0000, 11'h004, 8'he0, 8'he0, 16'h0001);
		fmmu_dir_out = 1'b0;
		tel(FBX_CMD_LRD, 16'h0001, 16'h0000, 11'h004, 8'h00, 8'he0, 16'h0001);
		tel(FBX_CMD_LRD, 16'h0002, 16'h0000, 11'h004, 8'h00, 8'h00, 16'h0000);
		tel(FBX_CMD_FPRD, 16'h1234, 16'h0040, 11'h004, 8'h00, 8'he0, 16'h0001);
		tel(FBX_CMD_LRW, 16'h0001, 16'h0000, 11'h004, 8'h00, 8'he0, 16'h0001);
		tel(FBX_CMD_ARMW, 16'h0000, 16'h0010, 11'h004, 8'h00, 8'ha0, 16'h0001);
		tel(FBX_CMD_FRMW, 16'h9999, 16'h0010, 11'h004, 8'hf0, 8'hf0, 16'h0001);
		tel(FBX_CMD_FPRD, 16'h1234, 16'h0010, 11'h004, 8'h00, 8'hf0, 16'h0001);
		// downstream stalls long enough for the input fifo to refuse bytes
		{last_in_segment, dn_ready} = 2'h0;
		fork
			tel(FBX_CMD_FPWR, 16'h1234, 16'h0060, 11'h014, 8'h70, 8'h70, 16'h0001);
			begin
				repeat (60) @(negedge ref_clk);
				dn_ready = 1'b1;
			end
		join
		check(16'(saw_full), 16'h0001, "fifo never refused");
		check(16'(link.fwd_ready), 16'h0001, "fifo not drained");
		wrap_up();
	end
endmodule
`default_nettype wire
